// *** design/twowire_pkg.sv ***
// Shared constants for the two-wire module management host.
// Assumes a 25 MHz system clock and a standard-rate bus of 100 kbit/s.
package twowire_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int BIT_TIME_NS = 10000;
  // Least quarter-bit time, rounded up to whole cycles
  localparam int QUARTER_CYCLES = (BIT_TIME_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // Command and setup field encodings
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic WIDTH_BYTE = 1'b0;
  localparam logic WIDTH_WORD = 1'b1;
  localparam logic PAD_OUTPUT = 1'b0;
  localparam logic PAD_INPUT = 1'b1;

  // Reset values of status
  localparam logic DONE_RESET = 1'b1;
  localparam logic FAULT_RESET = 1'b0;
  localparam logic LINE_IDLE = 1'b1;

  // Byte steps within one transaction
  localparam logic [2:0] STEP_ADDR = 3'h0;
  localparam logic [2:0] STEP_INDEX = 3'h1;
  localparam logic [2:0] STEP_THIRD = 3'h2;
  localparam logic [2:0] STEP_FOURTH = 3'h3;
  localparam logic [2:0] STEP_FIFTH = 3'h4;

  // Quarter-bit phases
  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;
  localparam logic [1:0] PH_3 = 2'h3;
  localparam logic [2:0] LAST_BIT = 3'h0;
  localparam logic [2:0] FIRST_BIT = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BYTE = 3'b010,
    ST_ACK = 3'b011,
    ST_STOP = 3'b100
  } engine_state_e;

endpackage

// *** design/twowire_sync3.sv ***
// Three-flop synchroniser with agreement filter for bus line inputs.
// Assumes inputs are asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/10ps
module twowire_sync3 #(
  parameter int WIDTH = 2,
  parameter logic RESET_VALUE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Lines
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] stage1Q;
  logic [WIDTH-1:0] stage2Q;
  logic [WIDTH-1:0] stage3Q;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("twowire_sync3: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1Q <= {WIDTH{RESET_VALUE}};
      stage2Q <= {WIDTH{RESET_VALUE}};
      stage3Q <= {WIDTH{RESET_VALUE}};
    end else begin
      stage1Q <= asyncIn;
      stage2Q <= stage1Q;
      stage3Q <= stage2Q;
    end
  end

  // Filter looks only at stages two and three
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      level_q <= {WIDTH{RESET_VALUE}};
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2Q[i] == stage3Q[i]) begin
          level_q[i] <= stage3Q[i];
        end
      end
    end
  end

endmodule

// *** design/twowire_module_mgmt_host.sv ***
// Two-wire management host: command engine plus direct pad control mode.
// Assumes open-drain pads outside (pull-ups on both lines); pins arrive asynchronously.
// Functional notes
// - Hardware mode runs a whole bus transaction after one command write.
// - Software mode drives clock and data pads straight from setup fields.
// - Done reads 1 only when idle or finished; poll before and after.
// - Write command: index, payload and direction 0 in one write.
// - Read command: index and direction 1; engine fetches data from slave.
// - Alert enable in a command raises an interrupt pulse at completion.
// - Fault flag reports a failed transaction; check it before using data.
// - Byte reads return valid data only in the low eight bits.
// - Word read: dummy write with index, restart, then two data bytes.
// - Byte read: dummy write with index, restart, then one data byte.
// - Word write: slave address, index, then two payload bytes.
// - Byte write: slave address, index, then payload low byte.
// - Software pad direction 0 makes an output, 1 makes an input.
// - Hardware mode has four fixed sequences; software mode allows any.
`timescale 1ns/10ps
module twowire_module_mgmt_host import twowire_pkg::*; #(
  parameter int QUARTER = QUARTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Setup fields
  input wire logic [6:0] targetDeviceAddress,
  input wire logic accessWidth,
  input wire logic softwareMode,
  input wire logic swSclValue,
  input wire logic swSclDirection,
  input wire logic swSdaValue,
  input wire logic swSdaDirection,
  output logic swSclLevel_q,
  output logic swSdaLevel_q,
  // Command fields
  input wire logic cmdWrite,
  input wire logic [7:0] targetRegisterIndex,
  input wire logic [15:0] cmdData,
  input wire logic transferDirection,
  input wire logic cmdAlertEnable,
  // Status
  output logic cmdDone_q,
  output logic cmdFault_q,
  output logic [15:0] readData_q,
  output logic alertIrq_q,
  // Two-wire pads
  input wire logic sclIn,
  output logic sclOut_q,
  output logic sclOe_q,
  input wire logic sdaIn,
  output logic sdaOut_q,
  output logic sdaOe_q
);

  localparam int TIMER_W = $clog2(QUARTER + 1);

  generate
    if (QUARTER < 2) begin : g_bad_quarter
      $error("twowire_module_mgmt_host: QUARTER must be at least 2");
    end
  endgenerate

  engine_state_e stateQ;
  logic [1:0] phaseQ;
  logic [2:0] bitQ;
  logic [2:0] stepQ;
  logic [7:0] shiftQ;
  logic [TIMER_W-1:0] timerQ;
  logic engSclLowQ;
  logic engSdaLowQ;
  logic [6:0] addrQ;
  logic [7:0] indexQ;
  logic [15:0] dataQ;
  logic isReadQ;
  logic isWordQ;
  logic alertEnQ;
  logic [1:0] lineLevel;
  logic sclHigh;
  logic sdaHigh;
  logic stretch;
  logic quarterEnd;
  logic accept;
  logic abort;
  logic finish;
  logic nackSeen;
  logic rxByte;
  logic lastRx;
  logic [7:0] curTx;
  logic [7:0] nextTx;

  twowire_sync3 #(
    .WIDTH(2),
    .RESET_VALUE(LINE_IDLE)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn({sclIn, sdaIn}),
    .level_q(lineLevel)
  );

  assign sclHigh = lineLevel[1];
  assign sdaHigh = lineLevel[0];

  // Slave may hold clock low; wait for the released line before sampling
  assign stretch = (phaseQ == PH_1) && !engSclLowQ && !sclHigh;
  assign quarterEnd = (stateQ != ST_IDLE) && (timerQ == TIMER_W'(QUARTER - 1)) && !stretch;
  assign accept = cmdWrite && cmdDone_q && !softwareMode && (stateQ == ST_IDLE);
  assign abort = softwareMode && (stateQ != ST_IDLE);
  assign finish = quarterEnd && (stateQ == ST_STOP) && (phaseQ == PH_3);
  assign nackSeen = quarterEnd && (stateQ == ST_ACK) && (phaseQ == PH_1) && !rxByte && sdaHigh;
  assign rxByte = isReadQ && (stepQ >= STEP_FOURTH);
  assign lastRx = !(isWordQ && (stepQ == STEP_FOURTH));

  // Byte sent at each step of the four fixed sequences
  function automatic logic [7:0] txByte(input logic [2:0] step);
    logic [7:0] b;
    b = 8'h00;
    case (step)
      STEP_ADDR: b = {addrQ, DIR_WRITE};
      STEP_INDEX: b = indexQ;
      STEP_THIRD: begin
        if (isReadQ) begin
          b = {addrQ, DIR_READ};
        end else if (isWordQ) begin
          b = dataQ[15:8];
        end else begin
          b = dataQ[7:0];
        end
      end
      default: b = dataQ[7:0];
    endcase
    return b;
  endfunction

  // Byte for this step and the next; process form so field changes re-evaluate
  always_comb begin
    curTx = txByte(stepQ);
    nextTx = txByte(stepQ + 3'h1);
  end

  // Command capture, all fields in one write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addrQ <= 7'h00;
      indexQ <= 8'h00;
      dataQ <= 16'h0000;
      isReadQ <= DIR_WRITE;
      isWordQ <= WIDTH_BYTE;
      alertEnQ <= 1'b0;
    end else if (accept) begin
      addrQ <= targetDeviceAddress;
      indexQ <= targetRegisterIndex;
      dataQ <= cmdData;
      isReadQ <= (transferDirection == DIR_READ);
      isWordQ <= (accessWidth == WIDTH_WORD);
      alertEnQ <= cmdAlertEnable;
    end
  end

  // Quarter-bit timer, held at its end while the slave stretches
  always_ff @(posedge clk) begin
    if (!reset_n || stateQ == ST_IDLE || quarterEnd) begin
      timerQ <= '0;
    end else if (timerQ != TIMER_W'(QUARTER - 1)) begin
      timerQ <= timerQ + TIMER_W'(1);
    end
  end

  // Transaction engine
  always_ff @(posedge clk) begin
    if (!reset_n || abort) begin
      stateQ <= ST_IDLE;
      phaseQ <= PH_0;
      bitQ <= FIRST_BIT;
      stepQ <= STEP_ADDR;
      shiftQ <= 8'h00;
      engSclLowQ <= 1'b0;
      engSdaLowQ <= 1'b0;
    end else if (accept) begin
      stateQ <= ST_START;
      phaseQ <= PH_0;
      stepQ <= STEP_ADDR;
      engSdaLowQ <= 1'b0;
    end else if (quarterEnd) begin
      phaseQ <= phaseQ + 2'h1;
      case (phaseQ)
        PH_0: engSclLowQ <= 1'b0;
        PH_1: begin
          if (stateQ == ST_START) begin
            engSdaLowQ <= 1'b1;
          end else if (stateQ == ST_STOP) begin
            engSdaLowQ <= 1'b0;
          end else if (stateQ == ST_BYTE && rxByte) begin
            shiftQ <= {shiftQ[6:0], sdaHigh};
          end
        end
        PH_2: begin
          if (stateQ != ST_STOP) begin
            engSclLowQ <= 1'b1;
          end
        end
        default: begin
          case (stateQ)
            ST_START: begin
              stateQ <= ST_BYTE;
              bitQ <= FIRST_BIT;
              shiftQ <= curTx;
              engSdaLowQ <= rxByte ? 1'b0 : !curTx[7];
            end
            ST_BYTE: begin
              if (bitQ == LAST_BIT) begin
                stateQ <= ST_ACK;
                // Master acknowledges all but the last received byte
                engSdaLowQ <= rxByte && !lastRx;
              end else begin
                bitQ <= bitQ - 3'h1;
                if (!rxByte) begin
                  shiftQ <= {shiftQ[6:0], 1'b0};
                  engSdaLowQ <= !shiftQ[6];
                end
              end
            end
            ST_ACK: begin
              if (cmdFault_q) begin
                stateQ <= ST_STOP;
                engSdaLowQ <= 1'b1;
              end else if (isReadQ && stepQ == STEP_INDEX) begin
                stateQ <= ST_START;
                stepQ <= STEP_THIRD;
                engSdaLowQ <= 1'b0;
              end else if (stepQ == STEP_ADDR || stepQ == STEP_INDEX ||
                           (stepQ == STEP_THIRD && (isReadQ || isWordQ)) ||
                           (stepQ == STEP_FOURTH && isReadQ && isWordQ)) begin
                stateQ <= ST_BYTE;
                stepQ <= stepQ + 3'h1;
                bitQ <= FIRST_BIT;
                shiftQ <= nextTx;
                engSdaLowQ <= (isReadQ && stepQ >= STEP_THIRD) ? 1'b0 : !nextTx[7];
              end else begin
                stateQ <= ST_STOP;
                engSdaLowQ <= 1'b1;
              end
            end
            default: begin
              stateQ <= ST_IDLE;
              engSclLowQ <= 1'b0;
              engSdaLowQ <= 1'b0;
            end
          endcase
        end
      endcase
    end
  end

  // Received bytes; byte reads leave the upper half zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readData_q <= 16'h0000;
    end else if (accept && transferDirection == DIR_READ) begin
      readData_q <= 16'h0000;
    end else if (quarterEnd && stateQ == ST_BYTE && phaseQ == PH_3 && bitQ == LAST_BIT &&
                 rxByte) begin
      if (isWordQ && stepQ == STEP_FOURTH) begin
        readData_q[15:8] <= shiftQ;
      end else begin
        readData_q[7:0] <= shiftQ;
      end
    end
  end

  // Done, fault and alert; hardware events never coincide with accept
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmdDone_q <= DONE_RESET;
      cmdFault_q <= FAULT_RESET;
      alertIrq_q <= 1'b0;
    end else begin
      alertIrq_q <= 1'b0;
      if (accept) begin
        cmdDone_q <= 1'b0;
        cmdFault_q <= 1'b0;
      end else if (abort) begin
        cmdDone_q <= 1'b1;
        cmdFault_q <= 1'b1;
        alertIrq_q <= alertEnQ;
      end else begin
        if (nackSeen) begin
          cmdFault_q <= 1'b1;
        end
        if (finish) begin
          cmdDone_q <= 1'b1;
          alertIrq_q <= alertEnQ;
        end
      end
    end
  end

  // Pads: open drain, enable pulls the line low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclOut_q <= 1'b0;
      sdaOut_q <= 1'b0;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      swSclLevel_q <= LINE_IDLE;
      swSdaLevel_q <= LINE_IDLE;
    end else begin
      sclOut_q <= 1'b0;
      sdaOut_q <= 1'b0;
      swSclLevel_q <= sclHigh;
      swSdaLevel_q <= sdaHigh;
      if (softwareMode) begin
        sclOe_q <= (swSclDirection == PAD_OUTPUT) && !swSclValue;
        sdaOe_q <= (swSdaDirection == PAD_OUTPUT) && !swSdaValue;
      end else begin
        sclOe_q <= engSclLowQ;
        sdaOe_q <= engSdaLowQ;
      end
    end
  end

endmodule

// *** bench/twowire_slave_model.sv ***
// Behavioural two-wire slave: 256-byte register file, auto-incrementing index.
// Assumes resolved open-drain lines with pull-ups; never stretches the clock.
`timescale 1ns/10ps
module twowire_slave_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  output logic pullSda
);
  logic [7:0] mem [256];
  logic [7:0] rx;
  logic [7:0] tx;
  logic [7:0] idx;
  logic active, sending, masterAck;
  int bitCnt, byteNo;
  initial begin
    pullSda = 1'b0;
    active = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'hee;
  end
  // Start or repeated start
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    sending = 1'b0;
    bitCnt = 0;
    byteNo = 0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    active = 1'b0;
    pullSda = 1'b0;
  end
  always @(posedge scl) if (active) begin
    if (bitCnt < 8) rx = {rx[6:0], sda};
    else masterAck = !sda;
    bitCnt++;
  end
  // Changes only while the clock is low, so never looks like start or stop
  always @(negedge scl) if (active) begin
    if (bitCnt == 8) begin
      if (sending) pullSda = 1'b0;
      else if (byteNo == 0) begin
        pullSda = (rx[7:1] == ADDR);
        sending = rx[0];
      end else begin
        pullSda = 1'b1;
        if (byteNo == 1) idx = rx;
        else mem[idx++] = rx;
      end
      byteNo++;
      if (!pullSda && !sending) active = 1'b0;
    end else if (bitCnt == 9) begin
      bitCnt = 0;
      pullSda = 1'b0;
      if (sending && (byteNo == 1 || masterAck)) begin
        tx = mem[idx++];
        pullSda = !tx[7];
      end else if (sending) active = 1'b0;
    end else if (sending) pullSda = !tx[7 - bitCnt];
  end
endmodule

// *** bench/twowire_host_checker.sv ***
// Port-level timing checks for the two-wire management host.
// Assumes it is bound to the host top module and sees only its ports.
`timescale 1ns/10ps
module twowire_host_checker import twowire_pkg::*; #(
  parameter int QUARTER = QUARTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Controls
  input wire logic softwareMode,
  input wire logic swSclDirection,
  input wire logic swSdaValue,
  input wire logic swSdaDirection,
  input wire logic cmdWrite,
  // Status and pads
  input wire logic cmdDone_q,
  input wire logic cmdFault_q,
  input wire logic alertIrq_q,
  input wire logic sclOe_q,
  input wire logic sdaOe_q
);
  localparam int START_MAX = 4 * QUARTER + 8;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic accept;
  assign accept = cmdWrite && cmdDone_q && !softwareMode;

  accept_clears_a: assert property (accept |=> !cmdDone_q && !cmdFault_q)
    else $error("done or fault not cleared at command accept");
  bus_start_a: assert property (accept |-> ##[1:START_MAX] (sdaOe_q && !sclOe_q))
    else $error("no start condition after command accept");
  sw_refuse_a: assert property (cmdWrite && softwareMode && cmdDone_q |=> cmdDone_q)
    else $error("command taken in software mode");
  sw_abort_a: assert property (!cmdDone_q && softwareMode |=> cmdDone_q && cmdFault_q)
    else $error("software mode did not abort the command");
  alert_done_a: assert property (alertIrq_q |-> $rose(cmdDone_q))
    else $error("alert without completion");
  alert_pulse_a: assert property (alertIrq_q |=> !alertIrq_q)
    else $error("alert longer than one cycle");
  fault_hold_a: assert property (cmdDone_q ##1 cmdDone_q |-> $stable(cmdFault_q))
    else $error("fault changed while idle");
  idle_lines_a: assert property ((cmdDone_q && !softwareMode)[*3] |-> !sclOe_q && !sdaOe_q)
    else $error("lines pulled while idle");
  sw_drive_a: assert property (softwareMode && !swSdaDirection && !swSdaValue
    ##1 softwareMode |-> sdaOe_q) else $error("data pad not driven low in software mode");
  sw_release_a: assert property (softwareMode && swSclDirection ##1 softwareMode
    |-> !sclOe_q) else $error("clock pad not released in software mode");
endmodule

bind twowire_module_mgmt_host twowire_host_checker #(.QUARTER(QUARTER)) chk (
  .clk(clk), .reset_n(reset_n), .softwareMode(softwareMode),
  .swSclDirection(swSclDirection), .swSdaValue(swSdaValue), .swSdaDirection(swSdaDirection),
  .cmdWrite(cmdWrite), .cmdDone_q(cmdDone_q), .cmdFault_q(cmdFault_q),
  .alertIrq_q(alertIrq_q), .sclOe_q(sclOe_q), .sdaOe_q(sdaOe_q));

// *** bench/twowire_module_mgmt_host_tb.sv ***
// Self-checking bench for the two-wire host: command engine and software pads.
// Assumes the slave model on pulled-up lines and a shortened quarter-bit time.
`timescale 1ns/10ps
module twowire_module_mgmt_host_tb;
  import twowire_pkg::*;
  logic clk, reset_n, accessWidth, softwareMode, cmdWrite, transferDirection, cmdAlertEnable;
  logic swSclValue, swSclDirection, swSdaValue, swSdaDirection, swSclLevel_q, swSdaLevel_q;
  logic cmdDone_q, cmdFault_q, alertIrq_q, pullSda, sclLine, sdaLine;
  logic sclOut_q, sclOe_q, sdaOut_q, sdaOe_q;
  logic [6:0] targetDeviceAddress;
  logic [7:0] targetRegisterIndex;
  logic [15:0] cmdData, readData_q;
  int err_total = 0;
  int num_checks = 0;
  int alertCnt = 0;

  twowire_module_mgmt_host #(.QUARTER(4)) dut (.clk(clk), .reset_n(reset_n),
    .targetDeviceAddress(targetDeviceAddress), .accessWidth(accessWidth),
    .softwareMode(softwareMode), .swSclValue(swSclValue), .swSclDirection(swSclDirection),
    .swSdaValue(swSdaValue), .swSdaDirection(swSdaDirection), .swSclLevel_q(swSclLevel_q),
    .swSdaLevel_q(swSdaLevel_q), .cmdWrite(cmdWrite), .targetRegisterIndex(targetRegisterIndex),
    .cmdData(cmdData), .transferDirection(transferDirection), .cmdAlertEnable(cmdAlertEnable),
    .cmdDone_q(cmdDone_q), .cmdFault_q(cmdFault_q), .readData_q(readData_q),
    .alertIrq_q(alertIrq_q), .sclIn(sclLine), .sclOut_q(sclOut_q), .sclOe_q(sclOe_q),
    .sdaIn(sdaLine), .sdaOut_q(sdaOut_q), .sdaOe_q(sdaOe_q));
  twowire_slave_model #(.ADDR(7'h50)) slave (.scl(sclLine), .sda(sdaLine), .pullSda(pullSda));
  // Open drain with pull-ups: the host may pull either line low, the slave only data
  assign sclLine = !sclOe_q;
  assign sdaLine = !(sdaOe_q || pullSda);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Counted mid-cycle, where the registered pulse has settled
  always @(negedge clk) if (alertIrq_q === 1'b1) alertCnt++;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic command(input logic wd, input logic dir, input logic [7:0] idx,
                         input logic [15:0] dat, input logic alrt);
    // Bench is the only agent on the command port, so it holds ownership
    @(posedge clk);
    #2;
    accessWidth = wd;
    transferDirection = dir;
    targetRegisterIndex = idx;
    cmdData = dat;
    cmdAlertEnable = alrt;
    cmdWrite = 1'b1;
    @(posedge clk);
    #2;
    cmdWrite = 1'b0;
    check("done after write", 16'h0, 16'(cmdDone_q));
  endtask
  task automatic finish_cmd(input logic expFault, input int expAlerts);
    int n;
    n = 0;
    while (cmdDone_q !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #2;
      n++;
    end
    @(posedge clk);
    #2;
    check("done", 16'h1, 16'(cmdDone_q));
    check("fault", 16'(expFault), 16'(cmdFault_q));
    check("alerts", 16'(expAlerts), 16'(alertCnt));
  endtask
  task automatic print_verdict;
    $display("Checks made %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #1000000;
    err_total++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    print_verdict();
  end

  initial begin
    {reset_n, accessWidth, softwareMode, cmdWrite, transferDirection, cmdAlertEnable} = '0;
    {swSclValue, swSdaValue, swSclDirection, swSdaDirection} = 4'h3;
    targetDeviceAddress = 7'h50;
    targetRegisterIndex = 8'h00;
    cmdData = 16'h0000;
    repeat (8) @(posedge clk);
    #2;
    reset_n = 1'b1;
    check("reset done", 16'h1, 16'(cmdDone_q));
    check("reset data", 16'h0, readData_q);
    command(WIDTH_WORD, DIR_WRITE, 8'h10, 16'ha55a, 1'b1);
    finish_cmd(1'b0, 1);
    check("word first", 16'h00a5, 16'(slave.mem[8'h10]));
    check("word second", 16'h005a, 16'(slave.mem[8'h11]));
    command(WIDTH_BYTE, DIR_WRITE, 8'h20, 16'h1234, 1'b0);
    command(WIDTH_BYTE, DIR_WRITE, 8'h30, 16'h0077, 1'b1);
    finish_cmd(1'b0, 1);
    check("byte", 16'h0034, 16'(slave.mem[8'h20]));
    check("byte next", 16'h00ee, 16'(slave.mem[8'h21]));
    check("busy write dropped", 16'h00ee, 16'(slave.mem[8'h30]));
    command(WIDTH_WORD, DIR_READ, 8'h10, 16'hffff, 1'b1);
    finish_cmd(1'b0, 2);
    check("word read", 16'ha55a, readData_q);
    command(WIDTH_BYTE, DIR_READ, 8'h11, 16'h0000, 1'b0);
    finish_cmd(1'b0, 2);
    check("byte read", 16'h005a, 16'(readData_q[7:0]));
    targetDeviceAddress = 7'h51;
    command(WIDTH_BYTE, DIR_WRITE, 8'h40, 16'h0011, 1'b1);
    finish_cmd(1'b1, 3);
    check("no ack no store", 16'h00ee, 16'(slave.mem[8'h40]));
    targetDeviceAddress = 7'h50;
    softwareMode = 1'b1;
    for (int k = 0; k < 4; k++) begin
      {swSdaDirection, swSdaValue} = 2'(k);
      {swSclDirection, swSclValue} = 2'(3 - k);
      repeat (8) @(posedge clk);
      #2;
      check("sw sda pull", 16'(k == 0), 16'(sdaOe_q));
      check("sw scl pull", 16'(k == 3), 16'(sclOe_q));
      check("sw sda level", 16'(k != 0), 16'(swSdaLevel_q));
      check("sw scl level", 16'(k != 3), 16'(swSclLevel_q));
      check("sw pad out", 16'h0, 16'({sclOut_q, sdaOut_q}));
    end
    cmdWrite = 1'b1;
    @(posedge clk);
    #2;
    cmdWrite = 1'b0;
    @(posedge clk);
    #2;
    check("sw mode refuses", 16'h1, 16'(cmdDone_q));
    {swSclDirection, swSdaDirection, softwareMode} = 3'h6;
    command(WIDTH_WORD, DIR_READ, 8'h10, 16'h0000, 1'b1);
    repeat (100) @(posedge clk);
    #2;
    softwareMode = 1'b1;
    finish_cmd(1'b1, 4);
    print_verdict();
  end
endmodule
